// ---- core/osd_regs.vh ----
// Register map, field positions, reset values and timing counts
// of the original size detector. Definitions only.
`ifndef OSD_REGS_VH
`define OSD_REGS_VH

// Clock and emitter timing
`define OSD_CLK_PERIOD_NS 20
`define OSD_EMIT_PERIOD_NS 130000
`define OSD_EMIT_ON_NS 8000
`define OSD_EMIT_PERIOD_CYC (`OSD_EMIT_PERIOD_NS / `OSD_CLK_PERIOD_NS)
`define OSD_EMIT_ON_CYC (`OSD_EMIT_ON_NS / `OSD_CLK_PERIOD_NS)

// Register byte offsets
`define OSD_CTRL_OFS 12'h000
`define OSD_STATUS_OFS 12'h004
`define OSD_INT_STAT_OFS 12'h008
`define OSD_INT_MASK_OFS 12'h00c

// Control fields
`define OSD_CTRL_SERIES_BIT 0
`define OSD_CTRL_EMIT_EN_BIT 1
`define OSD_CTRL_RESET 2'h2

// Status fields
`define OSD_ST_SIZE_LSB 0
`define OSD_ST_SELECT_BIT 4
`define OSD_ST_PLATEN_BIT 5
`define OSD_ST_COVER_BIT 6
`define OSD_ST_SENSE_LSB 8

// Interrupt status and mask fields
`define OSD_INT_SIZE_BIT 0
`define OSD_INT_PLATEN_BIT 1
`define OSD_INT_COVER_BIT 2
`define OSD_INT_RESET 3'h0

// Size codes
`define OSD_SIZE_NONE 4'h0
`define OSD_SIZE_A3 4'h1
`define OSD_SIZE_A4 4'h2
`define OSD_SIZE_B4 4'h3
`define OSD_SIZE_B5 4'h4
`define OSD_SIZE_A4R 4'h5
`define OSD_SIZE_A5 4'h6
`define OSD_SIZE_B5R 4'h7
`define OSD_SIZE_A5R 4'h8
`define OSD_SIZE_LD 4'h9
`define OSD_SIZE_LT 4'ha
`define OSD_SIZE_LG 4'hb
`define OSD_SIZE_LTR 4'hc
`define OSD_SIZE_ST 4'hd
`define OSD_SIZE_STR 4'he

`endif

// ---- core/osd_pulse_match.v ----
// One sensor point: checks that the receiver echoes the emitter pulse.
// Assumes a synchronised receiver level and strobes from the emitter timer.
`timescale 1ns/10ps

module osd_pulse_match (
  input wire ref_clk,
  input wire nrst,
  input wire rx_level,
  input wire on_strobe,
  input wire off_strobe,
  input wire period_end,
  output reg point_code
);

  reg on_ok;
  reg off_ok;

  // ***************************************************
  // Echo must be high in the on time, low in the off time
  // ***************************************************
  always @(posedge ref_clk) begin
    if (!nrst) begin
      on_ok <= 1'b0;
      off_ok <= 1'b0;
      point_code <= 1'b1;
    end else begin
      if (on_strobe) begin
        on_ok <= rx_level;
      end
      if (off_strobe) begin
        off_ok <= ~rx_level;
      end
      if (period_end) begin
        point_code <= ~(on_ok & off_ok);
        on_ok <= 1'b0;
        off_ok <= 1'b0;
      end
    end
  end

endmodule // osd_pulse_match

// ---- core/osd_detector.v ----
// Original size detector: emitter pulse drive, pulse-match sensing,
// size decoding and hold, APB register slave and interrupt.
// Assumes one 50 MHz clock, synchronous active-low reset, APB master.
//
// Function
// - A4 series: five bits decode eight sizes
// - LT series: four bits decode six sizes
// - Low means original present, high means absent
// - Platen off, match: report size, request selection
// - Platen off, no match: keep last state
// - All ones: no original, request no selection
// - Platen off: evaluate pattern every cycle
// - Platen on: freeze state, ignore sensors
// - Cover opened: set cover event only; size logic ignores the cover
// - Emitter pulse 130 us period, 8 us high
// - Only an echo of the pulse counts
`timescale 1ns/10ps
`include "osd_regs.vh"

module osd_detector #(
  parameter integer NUM_POINTS = 5,
  parameter integer CNT_W = 13,
  parameter integer PERIOD_CYC = `OSD_EMIT_PERIOD_CYC,
  parameter integer ON_CYC = `OSD_EMIT_ON_CYC
) (
  input wire ref_clk,
  input wire nrst,
  input wire [NUM_POINTS-1:0] sensor_rx,
  input wire platen_on,
  input wire document_feeder_cover,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg emit_drive,
  output reg [3:0] size_code,
  output reg size_select,
  output reg irq
);

  // Timer marks; CNT_W must hold PERIOD_CYC, the cut to it is deliberate
  // Sample points sit mid on time and mid off time, clear of edges
  localparam integer LAST_I = PERIOD_CYC - 1;
  localparam integer ON_SMP_I = ON_CYC / 2;
  localparam integer OFF_SMP_I = ON_CYC + (PERIOD_CYC - ON_CYC) / 2;
  localparam [CNT_W-1:0] LAST_CNT = LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] ON_CNT = ON_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] ON_SMP = ON_SMP_I[CNT_W-1:0];
  localparam [CNT_W-1:0] OFF_SMP = OFF_SMP_I[CNT_W-1:0];

  // ***************************************************
  // Input synchronisers
  // ***************************************************
  reg [NUM_POINTS+1:0] sync_a;
  reg [NUM_POINTS+1:0] sync_b;
  wire [NUM_POINTS-1:0] rx_s;
  wire platen_s;
  wire cover_s;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      sync_a <= {(NUM_POINTS+2){1'b0}};
      sync_b <= {(NUM_POINTS+2){1'b0}};
    end else begin
      sync_a <= {document_feeder_cover, platen_on, sensor_rx};
      sync_b <= sync_a;
    end
  end

  assign rx_s = sync_b[NUM_POINTS-1:0];
  assign platen_s = sync_b[NUM_POINTS];
  assign cover_s = sync_b[NUM_POINTS+1];

  // ***************************************************
  // Control register
  // ***************************************************
  reg [1:0] ctrl;
  wire series_lt;
  wire emit_en;

  assign series_lt = ctrl[`OSD_CTRL_SERIES_BIT];
  assign emit_en = ctrl[`OSD_CTRL_EMIT_EN_BIT];

  // ***************************************************
  // Emitter timer
  // ***************************************************
  reg [CNT_W-1:0] emit_cnt;
  reg on_strobe;
  reg off_strobe;
  reg period_end;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      emit_cnt <= {CNT_W{1'b0}};
      emit_drive <= 1'b0;
      on_strobe <= 1'b0;
      off_strobe <= 1'b0;
      period_end <= 1'b0;
    end else begin
      if (emit_cnt == LAST_CNT) begin
        emit_cnt <= {CNT_W{1'b0}};
      end else begin
        emit_cnt <= emit_cnt + 1'b1;
      end
      emit_drive <= emit_en & (emit_cnt < ON_CNT);
      on_strobe <= (emit_cnt == ON_SMP);
      off_strobe <= (emit_cnt == OFF_SMP);
      period_end <= (emit_cnt == LAST_CNT);
    end
  end

  // ***************************************************
  // Pulse match per sensor point
  // ***************************************************
  wire [NUM_POINTS-1:0] point_code;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_POINTS; gi = gi + 1) begin : g_point
      osd_pulse_match u_match (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .rx_level(rx_s[gi]),
        .on_strobe(on_strobe),
        .off_strobe(off_strobe),
        .period_end(period_end),
        .point_code(point_code[gi])
      );
    end
  endgenerate

  // ***************************************************
  // Size decoding
  // ***************************************************
  // Bit order: {point_1, point_2, point_3, center, rear}
  reg [3:0] decoded;
  reg all_absent;
  reg matched;

  always @* begin
    decoded = `OSD_SIZE_NONE;
    matched = 1'b1;
    if (series_lt) begin
      all_absent = &point_code[3:0];
      case (point_code[3:0])
        4'h0: decoded = `OSD_SIZE_LD;
        4'h1: decoded = `OSD_SIZE_LT;
        4'h8: decoded = `OSD_SIZE_LG;
        4'h9: decoded = `OSD_SIZE_LTR;
        4'hb: decoded = `OSD_SIZE_ST;
        4'hd: decoded = `OSD_SIZE_STR;
        default: matched = 1'b0;
      endcase
    end else begin
      all_absent = &point_code;
      case (point_code)
        5'h00: decoded = `OSD_SIZE_A3;
        5'h01: decoded = `OSD_SIZE_A4;
        5'h08: decoded = `OSD_SIZE_B4;
        5'h09: decoded = `OSD_SIZE_B5;
        5'h18: decoded = `OSD_SIZE_A4R;
        5'h19: decoded = `OSD_SIZE_A5;
        5'h1c: decoded = `OSD_SIZE_B5R;
        5'h1d: decoded = `OSD_SIZE_A5R;
        default: matched = 1'b0;
      endcase
    end
  end

  // ***************************************************
  // Size hold
  // ***************************************************
  reg [3:0] next_size;

  // Synced platen level: the size held is that of the cycle before
  always @* begin
    next_size = size_code;
    if (!platen_s) begin
      if (all_absent) begin
        next_size = `OSD_SIZE_NONE;
      end else if (matched) begin
        next_size = decoded;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      size_code <= `OSD_SIZE_NONE;
      size_select <= 1'b0;
    end else begin
      size_code <= next_size;
      size_select <= (next_size != `OSD_SIZE_NONE);
    end
  end

  // ***************************************************
  // Events
  // ***************************************************
  reg platen_d;
  reg cover_d;
  wire [2:0] events;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      platen_d <= 1'b0;
      cover_d <= 1'b0;
    end else begin
      platen_d <= platen_s;
      cover_d <= cover_s;
    end
  end

  // Size on any change, platen and cover on rising edges only; delay flops reset to the idle level
  assign events[`OSD_INT_SIZE_BIT] = (next_size != size_code);
  assign events[`OSD_INT_PLATEN_BIT] = platen_s & ~platen_d;
  assign events[`OSD_INT_COVER_BIT] = cover_s & ~cover_d;

  // ***************************************************
  // APB slave
  // ***************************************************
  reg [2:0] int_stat;
  reg [2:0] int_mask;
  reg [31:0] rd_mux;
  reg rd_err;
  wire access;
  wire commit;
  wire do_write;

  assign access = psel & penable;
  assign commit = access & pready;
  assign do_write = commit & pwrite & ~pslverr;

  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (paddr == `OSD_CTRL_OFS) begin
      rd_mux[1:0] = ctrl;
    end else if (paddr == `OSD_STATUS_OFS) begin
      rd_mux[`OSD_ST_SIZE_LSB+3:`OSD_ST_SIZE_LSB] = size_code;
      rd_mux[`OSD_ST_SELECT_BIT] = size_select;
      rd_mux[`OSD_ST_PLATEN_BIT] = platen_s;
      rd_mux[`OSD_ST_COVER_BIT] = cover_s;
      rd_mux[`OSD_ST_SENSE_LSB+NUM_POINTS-1:`OSD_ST_SENSE_LSB] = point_code;
    end else if (paddr == `OSD_INT_STAT_OFS) begin
      rd_mux[2:0] = int_stat;
    end else if (paddr == `OSD_INT_MASK_OFS) begin
      rd_mux[2:0] = int_mask;
    end else begin
      rd_err = 1'b1;
    end
  end

  // One wait state: answer registered in the first access cycle
  always @(posedge ref_clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & rd_err;
      if (access & ~pready & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ***************************************************
  // Registers and interrupt
  // ***************************************************
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl <= `OSD_CTRL_RESET;
      int_mask <= `OSD_INT_RESET;
      int_stat <= `OSD_INT_RESET;
      irq <= 1'b0;
    end else begin
      if (do_write && paddr == `OSD_CTRL_OFS) begin
        ctrl <= pwdata[1:0];
      end
      if (do_write && paddr == `OSD_INT_MASK_OFS) begin
        int_mask <= pwdata[2:0];
      end
      // Set wins over a write-one clear in the same cycle
      if (do_write && paddr == `OSD_INT_STAT_OFS) begin
        int_stat <= (int_stat & ~pwdata[2:0]) | events;
      end else begin
        int_stat <= int_stat | events;
      end
      irq <= |(int_stat & int_mask);
    end
  end

endmodule // osd_detector

// ---- verif/osd_detector_checker.sv ----
// Assertions on the ports of the original size detector.
// Bound into osd_detector; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module osd_chk #(
  parameter integer NUM_POINTS = 5,
  parameter integer PERIOD_CYC = 6500,
  parameter integer ON_CYC = 400
) (
  input wire ref_clk,
  input wire nrst,
  input wire [NUM_POINTS-1:0] sensor_rx,
  input wire platen_on,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire emit_drive,
  input wire [3:0] size_code,
  input wire size_select,
  input wire irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  reg e_prev;
  reg seen;
  reg [15:0] since_rise;
  reg [15:0] hi_cnt;
  reg [15:0] still_cnt;
  reg [NUM_POINTS-1:0] rx_prev;
  // ****
  // Emitter and sensor history
  // ****
  always @(posedge ref_clk) begin
    if (!nrst) begin
      e_prev <= 1'b0;
      seen <= 1'b0;
      since_rise <= 16'h0;
      hi_cnt <= 16'h0;
      still_cnt <= 16'h0;
      rx_prev <= {NUM_POINTS{1'b0}};
    end else begin
      e_prev <= emit_drive;
      rx_prev <= sensor_rx;
      hi_cnt <= emit_drive ? hi_cnt + 16'h1 : 16'h0;
      seen <= seen | (emit_drive & ~e_prev);
      since_rise <= (emit_drive && !e_prev) ? 16'h1 : since_rise + 16'h1;
      still_cnt <= (sensor_rx == rx_prev && !platen_on) ? still_cnt + 16'h1 : 16'h0;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_apb_one_wait: assert property (s_setup |=> s_answer)
    else $error("apb answer timing wrong");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_reset_clear: assert property ($rose(nrst) |-> size_code == 4'h0 && !size_select && !irq)
    else $error("outputs not cleared by reset");
  a_select_tie: assert property (size_select == (size_code != 4'h0))
    else $error("selection request disagrees with size");
  a_platen_hold: assert property (platen_on [*5] |=> $stable(size_code))
    else $error("size changed while platen on");
  a_emit_high: assert property ((e_prev && !emit_drive) |-> hi_cnt == ON_CYC)
    else $error("emitter high time wrong");
  a_emit_period: assert property ((emit_drive && !e_prev && seen) |-> since_rise == PERIOD_CYC)
    else $error("emitter period wrong");
  a_no_echo_none: assert property (still_cnt > 3 * PERIOD_CYC + 8 |-> size_code == 4'h0)
    else $error("steady light taken as original");
endmodule // osd_chk
bind osd_detector osd_chk #(.NUM_POINTS(NUM_POINTS), .PERIOD_CYC(PERIOD_CYC), .ON_CYC(ON_CYC))
  chk_u (.ref_clk(ref_clk), .nrst(nrst), .sensor_rx(sensor_rx), .platen_on(platen_on),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .emit_drive(emit_drive),
  .size_code(size_code), .size_select(size_select), .irq(irq));

// ---- verif/osd_sensor_model.sv ----
// Reflective sensors: echo the emitter where an original lies.
// Steady light pins a receiver high regardless of the emitter.
`timescale 1ns/10ps
module osd_sensor_model (
  input wire ref_clk,
  input wire emit_drive,
  input wire [4:0] present,
  input wire [4:0] steady,
  output logic [4:0] sensor_rx
);
  // Carriage kept parked home, so only the original shapes the echo
  always @(posedge ref_clk) begin
    sensor_rx <= steady | ({5{emit_drive}} & present);
  end
endmodule // osd_sensor_model

// ---- verif/osd_detector_tb.sv ----
// Self-checking bench of the original size detector.
// Shortened emitter period; APB master and sensor model.
`timescale 1ns/10ps
`include "osd_regs.vh"
module osd_detector_tb;
  localparam integer PER = 40;
  localparam [39:0] A4P = {5'h1d, 5'h1c, 5'h19, 5'h18, 5'h09, 5'h08, 5'h01, 5'h00};
  localparam [23:0] LTP = {4'hd, 4'hb, 4'h9, 4'h8, 4'h1, 4'h0};
  reg ref_clk, nrst, psel, penable, pwrite, platen_on, document_feeder_cover, e;
  reg [11:0] paddr;
  reg [31:0] pwdata, r;
  reg [4:0] present, steady;
  reg [15:0] seed;
  reg [3:0] cur;
  integer error_cnt, total_checks, i;
  wire [31:0] prdata;
  wire pready, pslverr, emit_drive, size_select, irq;
  wire [3:0] size_code;
  wire [4:0] sensor_rx;
  osd_detector #(.PERIOD_CYC(PER), .ON_CYC(8)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
    .sensor_rx(sensor_rx), .platen_on(platen_on), .document_feeder_cover(document_feeder_cover),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .emit_drive(emit_drive),
    .size_code(size_code), .size_select(size_select), .irq(irq));
  osd_sensor_model sens_u (.ref_clk(ref_clk), .emit_drive(emit_drive), .present(present),
    .steady(steady), .sensor_rx(sensor_rx));
  always #10 ref_clk = ~ref_clk;
  // ****
  // Helpers
  // ****
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Size code of a point pattern, f when unmatched
  function [3:0] exp_size(input ser, input [4:0] b);
    begin
      exp_size = 4'hf;
      if (!ser)
        case (b)
          5'h00: exp_size = 4'h1;
          5'h01: exp_size = 4'h2;
          5'h08: exp_size = 4'h3;
          5'h09: exp_size = 4'h4;
          5'h18: exp_size = 4'h5;
          5'h19: exp_size = 4'h6;
          5'h1c: exp_size = 4'h7;
          5'h1d: exp_size = 4'h8;
          5'h1f: exp_size = 4'h0;
        endcase
      else
        case (b[3:0])
          4'h0: exp_size = 4'h9;
          4'h1: exp_size = 4'ha;
          4'h8: exp_size = 4'hb;
          4'h9: exp_size = 4'hc;
          4'hb: exp_size = 4'hd;
          4'hd: exp_size = 4'he;
          4'hf: exp_size = 4'h0;
        endcase
    end
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      for (n = 0; n < 20 && pready !== 1'b1; n = n + 1) @(posedge ref_clk);
      if (n == 20) begin
        chk("apb_wait", 0, 1);
        finish_test;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // Change pattern in emitter off time, then check the settled result
  task put(input ser, input [4:0] b, input [4:0] s);
    reg [3:0] x, old;
    reg last;
    integer n;
    begin
      last = 1'b0;
      for (n = 0; n < 3 * PER && !(last === 1'b1 && emit_drive === 1'b0); n = n + 1) begin
        last = emit_drive;
        @(posedge ref_clk);
      end
      if (n == 3 * PER) begin
        chk("emit", 0, 1);
        finish_test;
      end
      present <= ~b;
      steady <= s;
      repeat (3 * PER + 10) @(posedge ref_clk);
      x = exp_size(ser, b | s);
      old = cur;
      if (x != 4'hf && !platen_on) cur = x;
      chk("size", size_code, cur);
      chk("select", size_select, cur != 4'h0);
      chk("irq", irq, cur != old);
      apb(1'b0, `OSD_STATUS_OFS, 0);
      chk("status", r[3:0], cur);
      if (!platen_on) chk("points", r[12:8], b | s);
      apb(1'b1, `OSD_INT_STAT_OFS, 32'h7);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, platen_on, document_feeder_cover} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    present = 5'h0;
    steady = 5'h0;
    seed = 16'hbd0e;
    cur = 4'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk("rst_size", size_code, 0);
    apb(1'b0, `OSD_CTRL_OFS, 0);
    chk("ctrl", r, `OSD_CTRL_RESET);
    apb(1'b0, 12'h010, 0);
    chk("slverr", e, 1);
    apb(1'b1, `OSD_INT_MASK_OFS, 32'h1);
    document_feeder_cover <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, `OSD_INT_STAT_OFS, 0);
    chk("cover", r[2], 1);
    for (i = 0; i < 8; i = i + 1) put(1'b0, A4P[i*5 +: 5], 5'h0);
    put(1'b0, 5'h02, 5'h0);
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      put(1'b0, seed[4:0], 5'h0);
    end
    put(1'b0, 5'h1f, 5'h0);
    apb(1'b1, `OSD_CTRL_OFS, 32'h3);
    for (i = 0; i < 6; i = i + 1) begin
      seed = lfsr(seed);
      put(1'b1, {seed[0], LTP[i*4 +: 4]}, 5'h0);
    end
    put(1'b1, 5'h0f, 5'h0);
    put(1'b1, 5'h00, 5'h0);
    platen_on <= 1'b1;
    repeat (10) @(posedge ref_clk);
    apb(1'b0, `OSD_INT_STAT_OFS, 0);
    chk("platen_evt", r[1], 1);
    put(1'b1, 5'h01, 5'h0);
    platen_on <= 1'b0;
    put(1'b1, 5'h01, 5'h0);
    put(1'b1, 5'h00, 5'h1f);
    // Emitter off lands in the off time after put, so no pulse is cut
    apb(1'b1, `OSD_CTRL_OFS, 32'h1);
    steady <= 5'h0;
    repeat (3 * PER + 10) @(posedge ref_clk);
    chk("emit_off", emit_drive, 0);
    chk("dark_size", size_code, 0);
    finish_test;
  end
endmodule // osd_detector_tb
